// >>> dv/ams_mode_seq_sva.sv
// Port checker for the operating-mode sequencer
`timescale 1ns/1ns
module ams_mode_seq_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Converter side
  input wire logic conv_rst,
  input wire logic mod_clk_en,
  input wire logic short_en,
  input wire logic vref_en,
  input wire logic chop_en,
  input wire logic [7:0] filter_rate_word,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr = psel && penable && pwrite && ce;
  wire logic mode_wr = wr && paddr == 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  sequence run_wr_s;
    mode_wr && pwdata[2:1] != 2'b00;
  endsequence
  sequence rst_pulse_s;
    conv_rst ##[1:2] !conv_rst [*3];
  endsequence
  wr_reset_a: assert property (mode_wr |=> conv_rst)
    else $error("no converter reset after mode write");
  run_start_a: assert property (run_wr_s |=> rst_pulse_s)
    else $error("reset pulse wrong after run mode write");
  pdown_hold_a: assert property ($rose(mod_clk_en) |->
    $past(mode_wr) || $past(mode_wr, 2))
    else $error("modulator clock left power-down without write");
  pdown_rst_a: assert property (!mod_clk_en |-> conv_rst)
    else $error("converter active in power-down");
  cal_src_a: assert property (!(short_en && vref_en))
    else $error("short and reference both connected");
  cal_start_a: assert property ($rose(short_en || vref_en) |->
    $past(mode_wr) || $past(mode_wr, 2))
    else $error("calibration source without mode write");
  chop_filt_a: assert property ((short_en || vref_en) && chop_en &&
    !conv_rst |-> filter_rate_word == 8'hff)
    else $error("chopped calibration not at largest filter word");
  chop_chg_a: assert property ($changed(chop_en) |-> $past(mode_wr))
    else $error("chop enable changed without mode write");
  bus_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase not ready");
  bad_addr_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
    else $error("unmapped access without error");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr))
    else $error("interrupt dropped without register write");
endmodule // ams_mode_seq_sva

bind ams_mode_seq ams_mode_seq_sva u_ams_mode_seq_sva (.pclk, .presetn, .ce,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .conv_rst,
  .mod_clk_en, .short_en, .vref_en, .chop_en, .filter_rate_word, .irq);

// >>> dv/tb.sv
// Self-checking bench for the operating-mode sequencer
`timescale 1ns/1ns
module tb;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, e;
  logic conv_rst, mod_clk_en, short_en, vref_en, chop_en, irq;
  logic [7:0] paddr, filter_rate_word;
  logic [31:0] pwdata, prdata, q;
  logic [23:0] sample_in;
  logic [3:0] input_pair_select;
  int failures, comparisons;
  ams_mode_seq u_ams_mode_seq (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_in,
    .conv_rst, .mod_clk_en, .short_en, .vref_en, .chop_en,
    .input_pair_select, .filter_rate_word, .irq);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, ams_pkg::OFF_MODE, 32'h0);
      n++;
    end while (q[2:0] !== ams_pkg::MODE_IDLE && n < 600);
  endtask
  task automatic wrap_up();
    $display("counts: %0d compared, %0d failed", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk1(conv_rst, 1'b1);
    chk1(chop_en, 1'b1);
    rd(ams_pkg::OFF_MODE, 32'h0);
    rd(ams_pkg::OFF_FILT, {24'h0, ams_pkg::FILT_RST});
    rd(ams_pkg::OFF_CTRL, 32'h07);
    chk({28'h0, input_pair_select}, 32'h0);
    chk1(mod_clk_en, 1'b0);
    $display("done reset");
  endtask
  task automatic t_single();
    sample_in <= 24'h5a5a5a;
    apb(1'b1, ams_pkg::OFF_FILT, 32'h01);
    rd(ams_pkg::OFF_FILT, 32'h0d);
    apb(1'b1, ams_pkg::OFF_IRQEN, 32'h3);
    apb(1'b1, ams_pkg::OFF_MODE, 32'h2);
    wait_idle();
    chk(q, 32'h1);
    sample_in <= 24'h123456;
    rd(ams_pkg::OFF_DATA, 32'h5a5a5a);
    apb(1'b0, ams_pkg::OFF_STAT, 32'h0);
    chk1(q[ams_pkg::ST_RDY], 1'b1);
    chk1(irq, 1'b1);
    apb(1'b1, ams_pkg::OFF_IRQCLR, 32'h1);
    chk1(irq, 1'b0);
    chk1(mod_clk_en, 1'b1);
    chk1(conv_rst, 1'b1);
    repeat (60) @(posedge pclk);
    rd(ams_pkg::OFF_DATA, 32'h5a5a5a);
    $display("done single");
  endtask
  task automatic t_cont();
    apb(1'b1, ams_pkg::OFF_MODE, 32'h3);
    repeat (80) @(posedge pclk);
    rd(ams_pkg::OFF_DATA, 32'h123456);
    sample_in <= 24'h654321;
    apb(1'b1, ams_pkg::OFF_MODE, 32'h3);
    repeat (80) @(posedge pclk);
    rd(ams_pkg::OFF_DATA, 32'h654321);
    rd(ams_pkg::OFF_MODE, 32'h3);
    apb(1'b1, ams_pkg::OFF_MODE, 32'h0);
    sample_in <= 24'h0f0f0f;
    repeat (80) @(posedge pclk);
    rd(ams_pkg::OFF_DATA, 32'h654321);
    chk1(mod_clk_en, 1'b0);
    $display("done continuous");
  endtask
  task automatic t_cal();
    logic [2:0] c;
    for (int i = 4; i < 8; i++) begin
      c = 3'(i);
      sample_in <= {21'h0a5a5a, c};
      apb(1'b1, ams_pkg::OFF_MODE, {29'h0, c});
      chk1(short_en, c == ams_pkg::MODE_IZS);
      chk1(vref_en, c == ams_pkg::MODE_IFS);
      chk({24'h0, filter_rate_word}, 32'hff);
      apb(1'b0, ams_pkg::OFF_STAT, 32'h0);
      chk1(q[ams_pkg::ST_RDY], 1'b0);
      wait_idle();
      chk(q, 32'h1);
      apb(1'b0, ams_pkg::OFF_STAT, 32'h0);
      chk1(q[ams_pkg::ST_CAL], 1'b1);
      chk({24'h0, filter_rate_word}, 32'h0d);
      rd(c[0] ? ams_pkg::OFF_FCAL : ams_pkg::OFF_ZCAL,
        {8'h0, 21'h0a5a5a, c});
    end
    $display("done calibration");
  endtask
  task automatic t_nochop();
    apb(1'b1, ams_pkg::OFF_IRQEN, 32'h0);
    apb(1'b1, ams_pkg::OFF_MODE, 32'h84);
    chk1(chop_en, 1'b0);
    chk({24'h0, filter_rate_word}, 32'h0d);
    wait_idle();
    chk(q, 32'h81);
    chk1(irq, 1'b0);
    apb(1'b1, ams_pkg::OFF_IRQEN, 32'h3);
    chk1(irq, 1'b1);
    rd(ams_pkg::OFF_IRQST, 32'h3);
    apb(1'b1, ams_pkg::OFF_IRQCLR, 32'h3);
    chk1(irq, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk1(e, 1'b1);
    chk(q, 32'h0);
    apb(1'b1, ams_pkg::OFF_CTRL, 32'h57);
    chk({28'h0, input_pair_select}, 32'h5);
    rd(ams_pkg::OFF_CTRL, 32'h57);
    ce <= 1'b0;
    apb(1'b1, ams_pkg::OFF_FILT, 32'h20);
    ce <= 1'b1;
    rd(ams_pkg::OFF_FILT, 32'h0d);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk1(mod_clk_en, 1'b0);
    rd(ams_pkg::OFF_MODE, 32'h0);
    $display("done no-chop and errors");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    sample_in = 24'h0;
    failures = 0;
    comparisons = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_single();
    t_cont();
    t_cal();
    t_nochop();
    wrap_up();
  end
endmodule // tb

// >>> hw/ams_mode_seq.sv
// Operating-mode sequencer with APB register file
`timescale 1ns/1ns
module ams_mode_seq #(
  parameter int DW = 24,
  parameter int CW = 12
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modulator side
  input wire logic [DW-1:0] sample_in,
  output logic conv_rst,
  output logic mod_clk_en,
  output logic short_en,
  output logic vref_en,
  output logic chop_en,
  output logic [3:0] input_pair_select,
  output logic [7:0] filter_rate_word,
  // Interrupt
  output logic irq
);
  typedef enum logic [1:0] {S_OFF, S_IDLE, S_RUN} ams_state_t;

  typedef struct packed {
    ams_state_t fsm;
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [7:0] filt;
    logic [7:0] stat;
    logic [DW-1:0] data;
    logic [DW-1:0] zcal;
    logic [DW-1:0] fcal;
    logic [ams_pkg::EV_W-1:0] ev;
    logic [ams_pkg::EV_W-1:0] ev_en;
    logic rst_p;
    logic [7:0] rdata;
  } ams_regs_t;

  ams_regs_t st_r, st_nxt;
  logic [DW-1:0] smp;
  logic rate_done;
  logic [2:0] md;
  logic chop_on;
  logic is_cal;
  logic [7:0] cal_sf;
  logic [CW-1:0] period;
  logic wr, rd;
  logic mode_wr;
  logic hit;

  ////////////////////////////////////////////////////////////////////////
  // Submodules

  ams_sample_sync #(.W(DW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(sample_in),
    .q(smp)
  );

  ams_rate_ctr #(.CW(CW)) u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clr(st_r.rst_p),
    .run(st_r.fsm == S_RUN),
    .period(period),
    .done(rate_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decoding

  assign md = st_r.mode[ams_pkg::MODE_FLD_LSB +: 3];
  assign chop_on = !st_r.mode[ams_pkg::MODE_CHOP_BIT];
  assign is_cal = md[2];
  // Calibration filter word selection
  assign cal_sf = (is_cal && chop_on) ? ams_pkg::FILT_MAX
                                      : st_r.filt;
  assign period = CW'(cal_sf) * CW'(ams_pkg::CYC_PER_SF);

  assign wr = psel && penable && pwrite && ce;
  assign rd = psel && !penable && !pwrite;
  assign mode_wr = wr && (paddr == ams_pkg::OFF_MODE);

  always_comb begin
    hit = 1'b1;
    if (paddr == ams_pkg::OFF_MODE) begin
      hit = 1'b1;
    end else if (paddr == ams_pkg::OFF_CTRL) begin
      hit = 1'b1;
    end else if (paddr == ams_pkg::OFF_FILT) begin
      hit = 1'b1;
    end else if (paddr == ams_pkg::OFF_STAT) begin
      hit = 1'b1;
    end else if (paddr == ams_pkg::OFF_DATA) begin
      hit = 1'b1;
    end else if (paddr == ams_pkg::OFF_ZCAL) begin
      hit = 1'b1;
    end else if (paddr == ams_pkg::OFF_FCAL) begin
      hit = 1'b1;
    end else if (paddr == ams_pkg::OFF_IRQST) begin
      hit = 1'b1;
    end else if (paddr == ams_pkg::OFF_IRQEN) begin
      hit = 1'b1;
    end else if (paddr == ams_pkg::OFF_IRQCLR) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_p = 1'b0;

    // Read data captured in setup phase
    if (rd) begin
      if (paddr == ams_pkg::OFF_MODE) begin
        st_nxt.rdata = st_r.mode;
      end else if (paddr == ams_pkg::OFF_CTRL) begin
        st_nxt.rdata = st_r.ctrl;
      end else if (paddr == ams_pkg::OFF_FILT) begin
        st_nxt.rdata = st_r.filt;
      end else if (paddr == ams_pkg::OFF_STAT) begin
        st_nxt.rdata = st_r.stat;
      end else if (paddr == ams_pkg::OFF_IRQST) begin
        st_nxt.rdata = 8'(st_r.ev);
      end else if (paddr == ams_pkg::OFF_IRQEN) begin
        st_nxt.rdata = 8'(st_r.ev_en);
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end

    // Conversion and calibration completion
    if (st_r.fsm == S_RUN && rate_done) begin
      case (md)
        ams_pkg::MODE_SINGLE: begin
          st_nxt.data = smp;
          st_nxt.stat[ams_pkg::ST_RDY] = 1'b1;
          st_nxt.mode[ams_pkg::MODE_FLD_LSB +: 3] = ams_pkg::MODE_IDLE;
          st_nxt.fsm = S_IDLE;
          st_nxt.ev[ams_pkg::EV_CONV] = 1'b1;
        end
        ams_pkg::MODE_CONT: begin
          st_nxt.data = smp;
          st_nxt.stat[ams_pkg::ST_RDY] = 1'b1;
          st_nxt.ev[ams_pkg::EV_CONV] = 1'b1;
        end
        ams_pkg::MODE_IZS, ams_pkg::MODE_SZS: begin
          st_nxt.zcal = smp;
          st_nxt.stat[ams_pkg::ST_RDY] = 1'b1;
          st_nxt.stat[ams_pkg::ST_CAL] = 1'b1;
          st_nxt.mode[ams_pkg::MODE_FLD_LSB +: 3] = ams_pkg::MODE_IDLE;
          st_nxt.fsm = S_IDLE;
          st_nxt.ev[ams_pkg::EV_CAL] = 1'b1;
        end
        ams_pkg::MODE_IFS, ams_pkg::MODE_SFS: begin
          st_nxt.fcal = smp;
          st_nxt.stat[ams_pkg::ST_RDY] = 1'b1;
          st_nxt.stat[ams_pkg::ST_CAL] = 1'b1;
          st_nxt.mode[ams_pkg::MODE_FLD_LSB +: 3] = ams_pkg::MODE_IDLE;
          st_nxt.fsm = S_IDLE;
          st_nxt.ev[ams_pkg::EV_CAL] = 1'b1;
        end
        default: begin
          st_nxt.fsm = S_IDLE;
        end
      endcase
    end

    // Register writes
    if (wr) begin
      if (paddr == ams_pkg::OFF_MODE) begin
        st_nxt.mode = pwdata[7:0];
        st_nxt.rst_p = 1'b1;
        case (pwdata[2:0])
          ams_pkg::MODE_PDOWN: st_nxt.fsm = S_OFF;
          ams_pkg::MODE_IDLE: st_nxt.fsm = S_IDLE;
          default: st_nxt.fsm = S_RUN;
        endcase
        if (pwdata[2]) begin
          st_nxt.stat[ams_pkg::ST_RDY] = 1'b0;
          st_nxt.stat[ams_pkg::ST_CAL] = 1'b0;
        end
      end else if (paddr == ams_pkg::OFF_CTRL) begin
        st_nxt.ctrl = pwdata[7:0];
      end else if (paddr == ams_pkg::OFF_FILT) begin
        if (pwdata[7:0] < ams_pkg::FILT_MIN) begin
          st_nxt.filt = ams_pkg::FILT_MIN;
        end else begin
          st_nxt.filt = pwdata[7:0];
        end
      end else if (paddr == ams_pkg::OFF_IRQEN) begin
        st_nxt.ev_en = pwdata[ams_pkg::EV_W-1:0];
      end else if (paddr == ams_pkg::OFF_IRQCLR) begin
        st_nxt.ev = st_nxt.ev & ~pwdata[ams_pkg::EV_W-1:0];
      end
    end

    // Set wins over clear
    if (st_r.fsm == S_RUN && rate_done && !mode_wr) begin
      if (md == ams_pkg::MODE_SINGLE || md == ams_pkg::MODE_CONT) begin
        st_nxt.ev[ams_pkg::EV_CONV] = 1'b1;
      end else if (is_cal) begin
        st_nxt.ev[ams_pkg::EV_CAL] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{fsm: S_OFF, mode: ams_pkg::MODE_RST,
                ctrl: ams_pkg::CTRL_RST, filt: ams_pkg::FILT_RST,
                stat: 8'h00, data: '0, zcal: '0, fcal: '0,
                ev: '0, ev_en: '0, rst_p: 1'b0,
                rdata: 8'h00};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = (st_r.rdata != 8'h00 || paddr != ams_pkg::OFF_DATA &&
                   paddr != ams_pkg::OFF_ZCAL &&
                   paddr != ams_pkg::OFF_FCAL) ? {24'h000000, st_r.rdata}
                : (paddr == ams_pkg::OFF_DATA) ? 32'(st_r.data)
                : (paddr == ams_pkg::OFF_ZCAL) ? 32'(st_r.zcal)
                : 32'(st_r.fcal);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Converter held in reset in idle, power-down and after mode write
  assign conv_rst = st_r.rst_p || st_r.fsm != S_RUN;
  assign mod_clk_en = st_r.fsm != S_OFF;
  assign short_en = st_r.fsm == S_RUN && md == ams_pkg::MODE_IZS;
  assign vref_en = st_r.fsm == S_RUN && md == ams_pkg::MODE_IFS;
  assign chop_en = chop_on;
  assign input_pair_select = st_r.ctrl[ams_pkg::CTRL_SEL_LSB +: 4];
  // Calibration word shown only while calibrating, then user word returns
  assign filter_rate_word = (st_r.fsm == S_RUN) ? cal_sf : st_r.filt;
  assign irq = |(st_r.ev & st_r.ev_en);
endmodule // ams_mode_seq

// >>> hw/ams_rate_ctr.sv
// Output-rate down counter for one conversion period
`timescale 1ns/1ns
module ams_rate_ctr #(
  parameter int CW = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control
  input wire logic clr,
  input wire logic run,
  input wire logic [CW-1:0] period,
  // Result
  output logic done
);
  typedef struct packed {
    logic [CW-1:0] cnt;
  } ams_rc_t;
  ams_rc_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clr || !run) begin
      st_nxt.cnt = period;
    end else if (st_r.cnt == '0) begin
      st_nxt.cnt = period;
    end else begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  assign done = run && !clr && (st_r.cnt == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule // ams_rate_ctr

// >>> hw/ams_sample_sync.sv
// Two-stage synchroniser for the modulator result bus
`timescale 1ns/1ns
module ams_sample_sync #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ams_ss_t;
  ams_ss_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  assign q = st_r.s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule // ams_sample_sync

// >>> pkg/ams_pkg.sv
// Package for the converter operating-mode sequencer
// Notes on behaviour
// - Reset mode is power-down until written
// - Idle holds filter, modulator reset; clocks run
// - Single mode: one conversion, update data
// - Single end: flags, back to idle 001
// - Continuous mode updates data at filter rate
// - Internal zero cal shorts enabled input
// - Internal full cal connects external reference
// - Mode change resets converter immediately
// - Same-value mode write also resets converter
// - Calibration write clears ready, starts calibration
// - Calibration end: cal regs, status, idle
// - Chop on: calibrate with largest filter word
// - Chop on: restore user filter word after
// - Chop off: calibrate with user filter word
// - Chop bit clear enables chop; default enabled
package ams_pkg;
  localparam logic [2:0] MODE_PDOWN = 3'h0;
  localparam logic [2:0] MODE_IDLE = 3'h1;
  localparam logic [2:0] MODE_SINGLE = 3'h2;
  localparam logic [2:0] MODE_CONT = 3'h3;
  localparam logic [2:0] MODE_IZS = 3'h4;
  localparam logic [2:0] MODE_IFS = 3'h5;
  localparam logic [2:0] MODE_SZS = 3'h6;
  localparam logic [2:0] MODE_SFS = 3'h7;
  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_FILT = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_DATA = 8'h10;
  localparam logic [7:0] OFF_ZCAL = 8'h14;
  localparam logic [7:0] OFF_FCAL = 8'h18;
  localparam logic [7:0] OFF_IRQST = 8'h1c;
  localparam logic [7:0] OFF_IRQEN = 8'h20;
  localparam logic [7:0] OFF_IRQCLR = 8'h24;
  // Mode register fields
  localparam int MODE_CHOP_BIT = 7;
  localparam int MODE_FLD_LSB = 0;
  localparam logic [7:0] MODE_RST = 8'h00;
  // Control register fields
  localparam int CTRL_SEL_LSB = 4;
  localparam logic [7:0] CTRL_RST = 8'h07;
  // Filter word
  localparam logic [7:0] FILT_RST = 8'h45;
  localparam logic [7:0] FILT_MAX = 8'hff;
  localparam logic [7:0] FILT_MIN = 8'h0d;
  // Status bits
  localparam int ST_RDY = 7;
  localparam int ST_CAL = 5;
  localparam int ST_ERR = 3;
  // Event bits
  localparam int EV_CONV = 0;
  localparam int EV_CAL = 1;
  localparam int EV_W = 2;
  // Conversion cycles per filter word unit
  localparam int CYC_PER_SF = 4;
endpackage
